// *** mcr_regs.sv ***
// Measurement configuration registers with offset application and converter controls
// Operation
// - Add local offset to local readings
// - Add remote two offset to its readings
// - Config five bit one sets offset scaling
// - Lock bit makes offsets read only
// - Detect enable exposes four wire presence bits
// - Flags read one when four-wire fan
// - Averaging disable speeds measurement fifteen times
// - Global bypass removes four input attenuators
// - Config four bits bypass individual attenuators
// - Single channel mode converts one input
// - Tach one high byte selects channel
`timescale 1ns/1ns
`default_nettype none
module mcr_regs
  import mcr_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  // Register port
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  // Fan presence sensing per tach input
  input wire logic [2:0] four_wire_sense_in,
  // Raw temperature results from converter, signed degrees
  input wire logic [9:0] local_temp_raw_in,
  input wire logic [9:0] remote_two_temp_raw_in,
  // Corrected temperature results
  output logic [9:0] local_temp_out,
  output logic [9:0] remote_two_temp_out,
  // Converter controls
  output logic averaging_disable_out,
  output logic [3:0] avg_speedup_out,
  output logic [3:0] attenuator_bypass_out,
  output logic single_channel_convert_out,
  output logic [2:0] channel_select_out,
  output logic scan_all_out
);

  typedef struct packed {
    logic [7:0] local_ofs;
    logic [7:0] rem2_ofs;
    logic [7:0] cfg2;
    logic [7:0] cfg1;
    logic [7:0] cfg4;
    logic [7:0] cfg5;
    logic [7:0] tachometer_input_one_hi;
    logic [7:0] rdata;
    logic [9:0] local_t;
    logic [9:0] rem2_t;
  } mcr_state_s;

  mcr_state_s s_q;
  mcr_state_s s_d;

  // Offset scaled by range bit: fine is 0.5 C per lsb, wide is 1 C per lsb
  function automatic logic [9:0] mcr_apply_ofs(input logic [9:0] raw, input logic [7:0] ofs,
                                               input logic wide);
    logic [9:0] ext;
    ext = wide ? {{2{ofs[7]}}, ofs} : {{3{ofs[7]}}, ofs[7:1]};
    return 10'(raw + ext);
  endfunction : mcr_apply_ofs

  // Addresses answered by this bank
  function automatic logic mcr_addr_mapped(input logic [7:0] a);
    return (a == MCR_ADDR_LOCAL_OFS) || (a == MCR_ADDR_REM2_OFS) || (a == MCR_ADDR_CFG2) ||
           (a == MCR_ADDR_CFG1) || (a == MCR_ADDR_CFG4) || (a == MCR_ADDR_CFG5) ||
           (a == MCR_ADDR_TACHOMETER_INPUT_ONE_MIN_HI);
  endfunction : mcr_addr_mapped

  logic lock;
  logic detect_en;
  assign lock = s_q.cfg1[MCR_CFG1_LOCK_BIT];
  assign detect_en = s_q.cfg2[MCR_CFG2_DETECT_EN_BIT];

  always_comb begin
    s_d = s_q;
    if (wr_in) begin
      case (addr_in)
        MCR_ADDR_LOCAL_OFS: if (!lock) s_d.local_ofs = wdata_in;
        MCR_ADDR_REM2_OFS: if (!lock) s_d.rem2_ofs = wdata_in;
        // Flags and reserved bit keep their value
        MCR_ADDR_CFG2: s_d.cfg2 = (wdata_in & MCR_CFG2_WR_MASK) | (s_q.cfg2 & ~MCR_CFG2_WR_MASK);
        MCR_ADDR_CFG1: begin
          s_d.cfg1 = wdata_in;
          // Lock only clears at reset
          s_d.cfg1[MCR_CFG1_LOCK_BIT] = wdata_in[MCR_CFG1_LOCK_BIT] | lock;
        end
        MCR_ADDR_CFG4: s_d.cfg4 = wdata_in;
        MCR_ADDR_CFG5: s_d.cfg5 = wdata_in;
        MCR_ADDR_TACHOMETER_INPUT_ONE_MIN_HI: s_d.tachometer_input_one_hi = wdata_in;
        default: ;
      endcase
    end
    // Flags follow sensing only while detection is on
    s_d.cfg2[MCR_CFG2_FLAG_LO +: 3] = detect_en ? four_wire_sense_in : 3'h0;
    s_d.rdata = 8'h00;
    if (rd_in) begin
      case (addr_in)
        MCR_ADDR_LOCAL_OFS: s_d.rdata = s_q.local_ofs;
        MCR_ADDR_REM2_OFS: s_d.rdata = s_q.rem2_ofs;
        MCR_ADDR_CFG2: s_d.rdata = s_q.cfg2;
        MCR_ADDR_CFG1: s_d.rdata = s_q.cfg1;
        MCR_ADDR_CFG4: s_d.rdata = s_q.cfg4;
        MCR_ADDR_CFG5: s_d.rdata = s_q.cfg5;
        MCR_ADDR_TACHOMETER_INPUT_ONE_MIN_HI: s_d.rdata = s_q.tachometer_input_one_hi;
        default: s_d.rdata = 8'h00;
      endcase
    end
    s_d.local_t = mcr_apply_ofs(local_temp_raw_in, s_q.local_ofs,
                                s_q.cfg5[MCR_CFG5_RANGE_BIT]);
    s_d.rem2_t = mcr_apply_ofs(remote_two_temp_raw_in, s_q.rem2_ofs,
                               s_q.cfg5[MCR_CFG5_RANGE_BIT]);
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      s_q <= '0;
      s_q.local_ofs <= MCR_RST_OFS;
      s_q.rem2_ofs <= MCR_RST_OFS;
      s_q.cfg2 <= MCR_RST_CFG2;
      s_q.cfg1 <= MCR_RST_CFG1;
      s_q.cfg4 <= MCR_RST_CFG4;
      s_q.cfg5 <= MCR_RST_CFG5;
      s_q.tachometer_input_one_hi <= MCR_RST_TACHOMETER_INPUT_ONE_MIN_HI;
    end else begin
      s_q <= s_d;
    end
  end

  assign rdata_out = s_q.rdata;
  assign local_temp_out = s_q.local_t;
  assign remote_two_temp_out = s_q.rem2_t;
  assign averaging_disable_out = s_q.cfg2[MCR_CFG2_AVG_OFF_BIT];
  assign avg_speedup_out = s_q.cfg2[MCR_CFG2_AVG_OFF_BIT] ? MCR_AVG_SPEEDUP : 4'h0;
  // Bit order: 2.5 V, core, 5 V, 12 V
  assign attenuator_bypass_out = {4{s_q.cfg2[MCR_CFG2_ATTENUATOR_BYPASS_BIT]}} | s_q.cfg4[7:4];
  assign single_channel_convert_out = s_q.cfg2[MCR_CFG2_SINGLE_BIT];
  assign channel_select_out = s_q.tachometer_input_one_hi[MCR_SEL_LO +: 3];
  assign scan_all_out = !s_q.cfg2[MCR_CFG2_SINGLE_BIT];

  property p_lock_holds;
    @(posedge clk_sys_in) disable iff (!rstn_in)
      lock && $past(lock) |-> $stable(s_q.local_ofs) && $stable(s_q.rem2_ofs);
  endproperty
  a_lock_holds: assert property (p_lock_holds) else $error("offset changed while locked");

  property p_flags_zero;
    @(posedge clk_sys_in) disable iff (!rstn_in)
      !$past(detect_en) |-> s_q.cfg2[3:1] == 3'h0;
  endproperty
  a_flags_zero: assert property (p_flags_zero) else $error("flags set while off");

  property p_flags_follow;
    @(posedge clk_sys_in) disable iff (!rstn_in)
      rstn_in && detect_en |=> s_q.cfg2[3:1] == $past(four_wire_sense_in);
  endproperty
  a_flags_follow: assert property (p_flags_follow) else $error("flags miss sense");

  property p_local_ofs;
    @(posedge clk_sys_in) disable iff (!rstn_in)
      rstn_in && s_q.cfg5[1] && $stable(s_q.local_ofs) |=>
        local_temp_out == 10'($past(local_temp_raw_in) + {{2{$past(s_q.local_ofs[7])}},
                                                          $past(s_q.local_ofs)});
  endproperty
  a_local_ofs: assert property (p_local_ofs) else $error("local offset wrong");

  property p_rem2_ofs;
    @(posedge clk_sys_in) disable iff (!rstn_in)
      rstn_in && !s_q.cfg5[1] |=> remote_two_temp_out == 10'($past(remote_two_temp_raw_in) +
        {{3{$past(s_q.rem2_ofs[7])}}, $past(s_q.rem2_ofs[7:1])});
  endproperty
  a_rem2_ofs: assert property (p_rem2_ofs) else $error("remote two offset wrong");

  property p_attenuator_bypass;
    @(posedge clk_sys_in) disable iff (!rstn_in)
      s_q.cfg2[5] |-> attenuator_bypass_out == 4'hf;
  endproperty
  a_attenuator_bypass: assert property (p_attenuator_bypass) else $error("global bypass missed");

  property p_attenuator_bypass_ind;
    @(posedge clk_sys_in) disable iff (!rstn_in)
      (attenuator_bypass_out & ~s_q.cfg4[7:4]) != 4'h0 |-> s_q.cfg2[5];
  endproperty
  a_attenuator_bypass_ind: assert property (p_attenuator_bypass_ind) else $error("bypass without cause");

  property p_single;
    @(posedge clk_sys_in) disable iff (!rstn_in)
      wr_in && addr_in == MCR_ADDR_CFG2 |=> single_channel_convert_out == $past(wdata_in[6])
        && averaging_disable_out == $past(wdata_in[4]);
  endproperty
  a_single: assert property (p_single) else $error("mode bits not written");

  property p_sel;
    @(posedge clk_sys_in) disable iff (!rstn_in)
      wr_in && addr_in == MCR_ADDR_TACHOMETER_INPUT_ONE_MIN_HI |=> channel_select_out == $past(wdata_in[7:5]);
  endproperty
  a_sel: assert property (p_sel) else $error("channel select wrong");

  property p_lock_sticky;
    @(posedge clk_sys_in) disable iff (!rstn_in)
      rstn_in && lock |=> lock;
  endproperty
  a_lock_sticky: assert property (p_lock_sticky) else $error("lock cleared");

  property p_local_wr;
    @(posedge clk_sys_in) disable iff (!rstn_in)
      rstn_in && !lock && wr_in && addr_in == MCR_ADDR_LOCAL_OFS |=>
        s_q.local_ofs == $past(wdata_in);
  endproperty
  a_local_wr: assert property (p_local_wr) else $error("local write lost");

  property p_local_locked;
    @(posedge clk_sys_in) disable iff (!rstn_in)
      rstn_in && lock && wr_in && addr_in == MCR_ADDR_LOCAL_OFS |=>
        $stable(s_q.local_ofs);
  endproperty
  a_local_locked: assert property (p_local_locked) else $error("local write taken");

  property p_rem2_wr;
    @(posedge clk_sys_in) disable iff (!rstn_in)
      rstn_in && !lock && wr_in && addr_in == MCR_ADDR_REM2_OFS |=>
        s_q.rem2_ofs == $past(wdata_in);
  endproperty
  a_rem2_wr: assert property (p_rem2_wr) else $error("remote two write lost");

  property p_rem2_locked;
    @(posedge clk_sys_in) disable iff (!rstn_in)
      rstn_in && lock && wr_in && addr_in == MCR_ADDR_REM2_OFS |=>
        $stable(s_q.rem2_ofs);
  endproperty
  a_rem2_locked: assert property (p_rem2_locked) else $error("remote two write taken");

  property p_local_hold;
    @(posedge clk_sys_in) disable iff (!rstn_in)
      rstn_in && !(wr_in && addr_in == MCR_ADDR_LOCAL_OFS) |=>
        $stable(s_q.local_ofs);
  endproperty
  a_local_hold: assert property (p_local_hold) else $error("local offset drift");

  property p_rdata_idle;
    @(posedge clk_sys_in) disable iff (!rstn_in)
      rstn_in && !rd_in |=> rdata_out == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");

  property p_rd_cfg2;
    @(posedge clk_sys_in) disable iff (!rstn_in)
      rstn_in && rd_in && addr_in == MCR_ADDR_CFG2 |=> rdata_out == $past(s_q.cfg2);
  endproperty
  a_rd_cfg2: assert property (p_rd_cfg2) else $error("config read wrong");

  property p_rd_local;
    @(posedge clk_sys_in) disable iff (!rstn_in)
      rstn_in && rd_in && addr_in == MCR_ADDR_LOCAL_OFS |=>
        rdata_out == $past(s_q.local_ofs);
  endproperty
  a_rd_local: assert property (p_rd_local) else $error("local read wrong");

  property p_rd_rem2;
    @(posedge clk_sys_in) disable iff (!rstn_in)
      rstn_in && rd_in && addr_in == MCR_ADDR_REM2_OFS |=>
        rdata_out == $past(s_q.rem2_ofs);
  endproperty
  a_rd_rem2: assert property (p_rd_rem2) else $error("remote two read wrong");

  property p_rd_unmapped;
    @(posedge clk_sys_in) disable iff (!rstn_in)
      rstn_in && rd_in && !mcr_addr_mapped(addr_in) |=> rdata_out == 8'h00;
  endproperty
  a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");

  property p_wr_unmapped;
    @(posedge clk_sys_in) disable iff (!rstn_in)
      rstn_in && wr_in && !mcr_addr_mapped(addr_in) |=>
        $stable({s_q.local_ofs, s_q.rem2_ofs, s_q.cfg1, s_q.cfg4, s_q.cfg5, s_q.tachometer_input_one_hi});
  endproperty
  a_wr_unmapped: assert property (p_wr_unmapped) else $error("unmapped write landed");

  property p_flags_off_now;
    @(posedge clk_sys_in) disable iff (!rstn_in)
      rstn_in && !detect_en |=> s_q.cfg2[3:1] == 3'h0;
  endproperty
  a_flags_off_now: assert property (p_flags_off_now) else $error("flags not cleared");

  property p_speedup_on;
    @(posedge clk_sys_in) disable iff (!rstn_in)
      averaging_disable_out |-> avg_speedup_out == MCR_AVG_SPEEDUP;
  endproperty
  a_speedup_on: assert property (p_speedup_on) else $error("speedup missing");

  property p_speedup_off;
    @(posedge clk_sys_in) disable iff (!rstn_in)
      !averaging_disable_out |-> avg_speedup_out == 4'h0;
  endproperty
  a_speedup_off: assert property (p_speedup_off) else $error("speedup while averaging");

  property p_scan_all;
    @(posedge clk_sys_in) disable iff (!rstn_in)
      scan_all_out == !single_channel_convert_out;
  endproperty
  a_scan_all: assert property (p_scan_all) else $error("scan mode mismatch");

  property p_attenuator_bypass_off;
    @(posedge clk_sys_in) disable iff (!rstn_in)
      !s_q.cfg2[5] |-> attenuator_bypass_out == s_q.cfg4[7:4];
  endproperty
  a_attenuator_bypass_off: assert property (p_attenuator_bypass_off) else $error("per channel bypass wrong");

  property p_local_half;
    @(posedge clk_sys_in) disable iff (!rstn_in)
      rstn_in && !s_q.cfg5[1] |=> local_temp_out == 10'($past(local_temp_raw_in) +
        {{3{$past(s_q.local_ofs[7])}}, $past(s_q.local_ofs[7:1])});
  endproperty
  a_local_half: assert property (p_local_half) else $error("local half offset wrong");

  property p_rem2_full;
    @(posedge clk_sys_in) disable iff (!rstn_in)
      rstn_in && s_q.cfg5[1] |=> remote_two_temp_out == 10'($past(remote_two_temp_raw_in) +
        {{2{$past(s_q.rem2_ofs[7])}}, $past(s_q.rem2_ofs)});
  endproperty
  a_rem2_full: assert property (p_rem2_full) else $error("remote two full wrong");

  property p_sel_hold;
    @(posedge clk_sys_in) disable iff (!rstn_in)
      rstn_in && !(wr_in && addr_in == MCR_ADDR_TACHOMETER_INPUT_ONE_MIN_HI) |=>
        $stable(channel_select_out);
  endproperty
  a_sel_hold: assert property (p_sel_hold) else $error("channel select drift");

  property p_mode_hold;
    @(posedge clk_sys_in) disable iff (!rstn_in)
      rstn_in && !(wr_in && addr_in == MCR_ADDR_CFG2) |=>
        $stable(single_channel_convert_out) && $stable(averaging_disable_out);
  endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("mode bits drift");

  property p_cfg5_wr;
    @(posedge clk_sys_in) disable iff (!rstn_in)
      rstn_in && wr_in && addr_in == MCR_ADDR_CFG5 |=> s_q.cfg5 == $past(wdata_in);
  endproperty
  a_cfg5_wr: assert property (p_cfg5_wr) else $error("range write lost");

endmodule : mcr_regs
`default_nettype wire

// *** mcr_pkg.sv ***
// Package of offsets, fields and reset values for the measurement configuration registers
`default_nettype none
package mcr_pkg;
  localparam logic [7:0] MCR_ADDR_LOCAL_OFS = 8'h71;
  localparam logic [7:0] MCR_ADDR_REM2_OFS = 8'h72;
  localparam logic [7:0] MCR_ADDR_CFG2 = 8'h73;
  localparam logic [7:0] MCR_ADDR_CFG1 = 8'h40;
  localparam logic [7:0] MCR_ADDR_CFG4 = 8'h7d;
  localparam logic [7:0] MCR_ADDR_CFG5 = 8'h7c;
  localparam logic [7:0] MCR_ADDR_TACHOMETER_INPUT_ONE_MIN_HI = 8'h55;
  localparam logic [7:0] MCR_RST_OFS = 8'h00;
  localparam logic [7:0] MCR_RST_CFG2 = 8'h00;
  localparam logic [7:0] MCR_RST_CFG1 = 8'h00;
  localparam logic [7:0] MCR_RST_CFG4 = 8'h00;
  localparam logic [7:0] MCR_RST_CFG5 = 8'h00;
  localparam logic [7:0] MCR_RST_TACHOMETER_INPUT_ONE_MIN_HI = 8'hff;
  localparam int MCR_CFG1_LOCK_BIT = 1;
  localparam int MCR_CFG5_RANGE_BIT = 1;
  localparam int MCR_CFG2_DETECT_EN_BIT = 0;
  localparam int MCR_CFG2_FLAG_LO = 1;
  localparam int MCR_CFG2_AVG_OFF_BIT = 4;
  localparam int MCR_CFG2_ATTENUATOR_BYPASS_BIT = 5;
  localparam int MCR_CFG2_SINGLE_BIT = 6;
  localparam int MCR_CFG2_RES_BIT = 7;
  localparam int MCR_SEL_LO = 5;
  localparam logic [7:0] MCR_CFG2_WR_MASK = 8'h71;
  localparam logic [2:0] MCR_CH_REMOTE_ONE = 3'h5;
  localparam logic [2:0] MCR_CH_LOCAL = 3'h6;
  localparam logic [2:0] MCR_CH_REMOTE_TWO = 3'h7;
  localparam logic [3:0] MCR_AVG_SPEEDUP = 4'hf;
endpackage : mcr_pkg
`default_nettype wire

// *** mcr_host.sv ***
// Host model that speaks the plain register port
`timescale 1ns/1ns
`default_nettype none
module mcr_host
  import mcr_pkg::*;
(
  // Clock
  input wire logic clk_sys_in,
  // Register port
  output logic [7:0] addr_out,
  output logic [7:0] wdata_out,
  output logic wr_out,
  output logic rd_out,
  input wire logic [7:0] rdata_in
);
  initial begin
    addr_out = 8'h00;
    wdata_out = 8'h00;
    wr_out = 1'h0;
    rd_out = 1'h0;
  end
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    addr_out <= a;
    wdata_out <= d;
    wr_out <= 1'h1;
    @(posedge clk_sys_in);
    wr_out <= 1'h0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys_in);
    addr_out <= a;
    rd_out <= 1'h1;
    @(posedge clk_sys_in);
    rd_out <= 1'h0;
    #1 d = rdata_in;
  endtask : rd_reg
  // Keeps the reserved bit as read back
  task automatic set_cfg2(input logic [7:0] v);
    logic [7:0] cur;
    rd_reg(MCR_ADDR_CFG2, cur);
    wr_reg(MCR_ADDR_CFG2, (cur & 8'h80) | (v & 8'h7f));
  endtask : set_cfg2
endmodule : mcr_host
`default_nettype wire

// *** mcr_regs_tb.sv ***
// Self-checking testbench for the measurement configuration registers
`timescale 1ns/1ns
`default_nettype none
module mcr_regs_tb;
  import mcr_pkg::*;
  logic clk_sys_in = 1'h0;
  logic rstn_in = 1'h0;
  logic [7:0] addr, wdata, rdata, rv;
  logic wr, rd, avg_off, single, scan_all;
  logic [2:0] sense = 3'h0, sel;
  logic [9:0] lraw = 10'h000, rraw = 10'h000, lout, rout;
  logic [3:0] speedup, bypass;
  int err_total = 0;
  int total_checks = 0;
  always #5 clk_sys_in = ~clk_sys_in;
  mcr_host u_mcr_host (.clk_sys_in(clk_sys_in), .addr_out(addr), .wdata_out(wdata),
    .wr_out(wr), .rd_out(rd), .rdata_in(rdata));
  mcr_regs u_mcr_regs (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .addr_in(addr),
    .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
    .four_wire_sense_in(sense), .local_temp_raw_in(lraw), .remote_two_temp_raw_in(rraw),
    .local_temp_out(lout), .remote_two_temp_out(rout), .averaging_disable_out(avg_off),
    .avg_speedup_out(speedup), .attenuator_bypass_out(bypass),
    .single_channel_convert_out(single), .channel_select_out(sel), .scan_all_out(scan_all));
  task automatic check(input string what, input logic [9:0] seen, input logic [9:0] exp);
    total_checks = total_checks + 1;
    if (seen !== exp) begin
      err_total = err_total + 1;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
    u_mcr_host.rd_reg(a, rv);
    check(what, {2'h0, rv}, {2'h0, exp});
  endtask : rd_chk
  task automatic settle();
    repeat (2) @(posedge clk_sys_in);
    #1;
  endtask : settle
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : close_out
  initial begin
    #50000;
    err_total = err_total + 1;
    close_out();
  end
  initial begin
    repeat (3) @(posedge clk_sys_in);
    rstn_in <= 1'h1;
    #1;
    check("sel_rst", {7'h00, sel}, 10'h007);
    check("scan_rst", {9'h000, scan_all}, 10'h001);
    rd_chk("local_ofs_rst", MCR_ADDR_LOCAL_OFS, MCR_RST_OFS);
    rd_chk("rem2_ofs_rst", MCR_ADDR_REM2_OFS, MCR_RST_OFS);
    rd_chk("cfg2_rst", MCR_ADDR_CFG2, MCR_RST_CFG2);
    u_mcr_host.wr_reg(8'h20, 8'hff);
    rd_chk("unmapped", 8'h20, 8'h00);
    // Full-scale offsets
    u_mcr_host.wr_reg(MCR_ADDR_CFG5, 8'h02);
    lraw <= 10'h010;
    rraw <= 10'h020;
    u_mcr_host.wr_reg(MCR_ADDR_LOCAL_OFS, 8'h05);
    u_mcr_host.wr_reg(MCR_ADDR_REM2_OFS, 8'hfe);
    settle();
    check("local_full", lout, 10'h015);
    check("rem2_full", rout, 10'h01e);
    // Half-scale offsets
    u_mcr_host.wr_reg(MCR_ADDR_CFG5, 8'h00);
    settle();
    check("local_half", lout, 10'h012);
    check("rem2_half", rout, 10'h01f);
    sense <= 3'h5;
    u_mcr_host.set_cfg2(8'h0f);
    settle();
    rd_chk("cfg2_detect", MCR_ADDR_CFG2, 8'h0b);
    u_mcr_host.set_cfg2(8'h1e);
    settle();
    rd_chk("cfg2_nodetect", MCR_ADDR_CFG2, 8'h10);
    check("avg_off", {speedup, 5'h00, avg_off}, {MCR_AVG_SPEEDUP, 6'h01});
    u_mcr_host.set_cfg2(8'h20);
    settle();
    check("bypass_all", {6'h00, bypass}, 10'h00f);
    u_mcr_host.set_cfg2(8'h40);
    u_mcr_host.wr_reg(MCR_ADDR_CFG4, 8'h50);
    settle();
    check("bypass_one", {6'h00, bypass}, 10'h005);
    check("single", {8'h00, single, scan_all}, 10'h002);
    for (int i = 0; i < 8; i++) begin
      u_mcr_host.wr_reg(MCR_ADDR_TACHOMETER_INPUT_ONE_MIN_HI, {3'(i), 5'h00});
      settle();
      check("chan_sel", {7'h00, sel}, 10'(i));
    end
    // Lock, then offsets refuse writes
    u_mcr_host.wr_reg(MCR_ADDR_CFG1, 8'h02);
    u_mcr_host.wr_reg(MCR_ADDR_LOCAL_OFS, 8'haa);
    u_mcr_host.wr_reg(MCR_ADDR_REM2_OFS, 8'h33);
    u_mcr_host.wr_reg(MCR_ADDR_CFG1, 8'h00);
    u_mcr_host.wr_reg(MCR_ADDR_LOCAL_OFS, 8'h77);
    rd_chk("local_locked", MCR_ADDR_LOCAL_OFS, 8'h05);
    rd_chk("rem2_locked", MCR_ADDR_REM2_OFS, 8'hfe);
    rd_chk("lock_kept", MCR_ADDR_CFG1, 8'h02);
    // Reset in mid-run releases the lock
    @(posedge clk_sys_in);
    rstn_in <= 1'h0;
    repeat (3) @(posedge clk_sys_in);
    rstn_in <= 1'h1;
    rd_chk("local_ofs_rerst", MCR_ADDR_LOCAL_OFS, MCR_RST_OFS);
    u_mcr_host.wr_reg(MCR_ADDR_LOCAL_OFS, 8'h77);
    rd_chk("local_unlocked", MCR_ADDR_LOCAL_OFS, 8'h77);
    close_out();
  end
endmodule : mcr_regs_tb
`default_nettype wire
